// *** src/dioc_pkg.sv ***
// Shared constants, register map and carrier types for the digital I/O counter block.
// Assumes a single 25 MHz core clock and an AXI4-Lite register master.
package dioc_pkg;
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned SAMPLE_US = 500;
   localparam int unsigned SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;
   localparam int unsigned NLINES = 8;
   localparam int unsigned PRESCALE = 8;
   localparam logic [7:0] THR_MIN = 8'h01;
   localparam logic [7:0] THR_RST = 8'h01;
   localparam logic [7:0] ALARM_RST = 8'h01;
   localparam logic [7:0] OUT_CAPABLE = 8'h7E;
   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_FILT_EN = 8'h08;
   localparam logic [7:0] A_BOTH_EDGE = 8'h0C;
   localparam logic [7:0] A_INVERT = 8'h10;
   localparam logic [7:0] A_ENC_EN = 8'h14;
   localparam logic [7:0] A_OUT_LVL = 8'h18;
   localparam logic [7:0] A_PULSE_LEN = 8'h1C;
   localparam logic [7:0] A_PULSE_GO = 8'h20;
   localparam logic [7:0] A_LVL_SEL = 8'h24;
   localparam logic [7:0] A_ALARM = 8'h28;
   localparam logic [7:0] A_TIME = 8'h2C;
   localparam logic [7:0] A_THR0 = 8'h40;
   localparam logic [7:0] A_CNT0 = 8'h60;
   localparam logic [7:0] A_TS0 = 8'h80;
   localparam logic [7:0] A_ENC0 = 8'hA0;
   localparam logic [7:0] A_ENCTS0 = 8'hB0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Line configuration carrier: per-line filter, edge and invert bits, per-pair encoder enables
   typedef struct packed {
      logic [7:0] filt_en;
      logic [7:0] both_edge;
      logic [7:0] invert;
      logic [2:0] enc_en;
   } dioc_cfg_s;
   typedef enum logic {DIOC_STOP, DIOC_RUN} dioc_mode_e;
endpackage

// *** src/dioc_top.sv ***
// Eight-line digital input/output block: filters, edge counters, encoders, open-drain outputs.
// Assumes pins synchronous to core_clk_in; registers reached by an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none

module dioc_top
   import dioc_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
)(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] line_in,
   output logic [7:0] line_oe_out,
   output logic [7:0] line_o_out,
   output logic [1:0] level_sel_out,
   output logic run_out,
   input wire logic [7:0] s_awaddr_in,
   input wire logic s_awvalid_in,
   output logic s_awready_out,
   input wire logic [31:0] s_wdata_in,
   input wire logic [3:0] s_wstrb_in,
   input wire logic s_wvalid_in,
   output logic s_wready_out,
   output logic [1:0] s_bresp_out,
   output logic s_bvalid_out,
   input wire logic s_bready_in,
   input wire logic [7:0] s_araddr_in,
   input wire logic s_arvalid_in,
   output logic s_arready_out,
   output logic [31:0] s_rdata_out,
   output logic [1:0] s_rresp_out,
   output logic s_rvalid_out,
   input wire logic s_rready_in
);
   import dioc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   dioc_mode_e mode_ff;
   dioc_cfg_s cfg_ff;
   logic run_pulse;
   logic [7:0] thr_ff [NLINES];
   logic [7:0] alarm_ff;
   logic [7:0] out_lvl_ff;
   logic [15:0] pulse_len_ff;
   logic [7:0] pulse_act_ff;
   logic [15:0] pulse_cnt_ff;
   logic [1:0] lvl_sel_ff;
   logic [31:0] time_ff;
   logic [31:0] tick_cnt_ff;
   logic tick;
   logic [7:0] filt_cnt_ff [NLINES];
   logic [7:0] filt_out_ff;
   logic [7:0] cnt_in_prev_ff;
   logic [31:0] cnt_ff [NLINES];
   logic [31:0] ts_ff [NLINES];
   logic [7:0] since_ff [NLINES];
   logic [7:0] alarm_flag_ff;
   logic [2:0] pre_ff;
   logic pre_q_ff;
   logic [31:0] enc_ff [3];
   logic [31:0] enc_ts_ff [3];
   logic [1:0] enc_prev_ff [3];
   logic [7:0] samp;
   logic [7:0] enc_lines;
   logic [7:0] cnt_step;
   logic fast_prev_ff;
   logic [7:0] alarm_clr;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   logic [7:0] awaddr_ff;
   logic aw_have_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic w_have_ff;
   logic wr_go;
   logic [31:0] wmask;
   assign wr_go = aw_have_ff & w_have_ff & ~s_bvalid_out;
   assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

   // Address and data capture in either order
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
      end
      else
      begin
         if (s_awvalid_in & s_awready_out)
         begin
            aw_have_ff <= 1'b1;
            awaddr_ff <= s_awaddr_in;
         end
         else if (wr_go)
            aw_have_ff <= 1'b0;
         if (s_wvalid_in & s_wready_out)
         begin
            w_have_ff <= 1'b1;
            wdata_ff <= s_wdata_in;
            wstrb_ff <= s_wstrb_in;
         end
         else if (wr_go)
            w_have_ff <= 1'b0;
      end
   end

   // Ready flags and write response
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         s_awready_out <= 1'b0;
         s_wready_out <= 1'b0;
         s_bvalid_out <= 1'b0;
         s_bresp_out <= RESP_OKAY;
      end
      else
      begin
         s_awready_out <= ~aw_have_ff & ~(s_awvalid_in & s_awready_out) & ~s_bvalid_out;
         s_wready_out <= ~w_have_ff & ~(s_wvalid_in & s_wready_out) & ~s_bvalid_out;
         if (wr_go)
         begin
            s_bvalid_out <= 1'b1;
            s_bresp_out <= (awaddr_ff < A_THR0 && awaddr_ff > A_TIME) ? RESP_SLVERR : RESP_OKAY;
         end
         else if (s_bready_in)
            s_bvalid_out <= 1'b0;
      end
   end

   // Read mux
   logic [31:0] rd_mux;
   logic rd_ok;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b1;
      if (s_araddr_in >= A_THR0 && s_araddr_in < A_CNT0)
         rd_mux = {24'h00_0000, thr_ff[s_araddr_in[4:2]]};
      else if (s_araddr_in >= A_CNT0 && s_araddr_in < A_TS0)
         rd_mux = cnt_ff[s_araddr_in[4:2]];
      else if (s_araddr_in >= A_TS0 && s_araddr_in < A_ENC0)
         rd_mux = ts_ff[s_araddr_in[4:2]];
      else if (s_araddr_in >= A_ENC0 && s_araddr_in < A_ENC0 + 8'h0C)
         rd_mux = enc_ff[s_araddr_in[3:2]];
      else if (s_araddr_in >= A_ENCTS0 && s_araddr_in < A_ENCTS0 + 8'h0C)
         rd_mux = enc_ts_ff[s_araddr_in[3:2]];
      else
         unique case (s_araddr_in)
            A_CTRL: rd_mux = {31'h0000_0000, mode_ff == DIOC_RUN};
            A_STAT: rd_mux = {16'h0000, filt_out_ff, alarm_flag_ff};
            A_FILT_EN: rd_mux = {24'h00_0000, cfg_ff.filt_en};
            A_BOTH_EDGE: rd_mux = {24'h00_0000, cfg_ff.both_edge};
            A_INVERT: rd_mux = {24'h00_0000, cfg_ff.invert};
            A_ENC_EN: rd_mux = {29'h0000_0000, cfg_ff.enc_en};
            A_OUT_LVL: rd_mux = {24'h00_0000, out_lvl_ff};
            A_PULSE_LEN: rd_mux = {16'h0000, pulse_len_ff};
            A_PULSE_GO: rd_mux = {24'h00_0000, pulse_act_ff};
            A_LVL_SEL: rd_mux = {30'h0000_0000, lvl_sel_ff};
            A_ALARM: rd_mux = {24'h00_0000, alarm_ff};
            A_TIME: rd_mux = time_ff;
            default: rd_ok = 1'b0;
         endcase
   end

   // Read channel
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         s_arready_out <= 1'b0;
         s_rvalid_out <= 1'b0;
         s_rdata_out <= 32'h0000_0000;
         s_rresp_out <= RESP_OKAY;
      end
      else if (s_arvalid_in & s_arready_out)
      begin
         s_arready_out <= 1'b0;
         s_rvalid_out <= 1'b1;
         s_rdata_out <= rd_mux;
         s_rresp_out <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_rvalid_out)
      begin
         if (s_rready_in)
            s_rvalid_out <= 1'b0;
      end
      else
         s_arready_out <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers
   assign run_pulse = wr_go && awaddr_ff == A_CTRL && wstrb_ff[0] && wdata_ff[0] && mode_ff == DIOC_STOP;
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         mode_ff <= DIOC_STOP;
         cfg_ff <= '0;
         out_lvl_ff <= 8'h00;
         pulse_len_ff <= 16'h0001;
         lvl_sel_ff <= 2'b00;
         alarm_ff <= ALARM_RST;
      end
      else if (wr_go)
      begin
         unique case (awaddr_ff)
            A_CTRL: if (wstrb_ff[0]) mode_ff <= wdata_ff[0] ? DIOC_RUN : DIOC_STOP;
            A_FILT_EN: cfg_ff.filt_en <= (cfg_ff.filt_en & ~wmask[7:0]) | (wdata_ff[7:0] & wmask[7:0]);
            A_BOTH_EDGE: cfg_ff.both_edge <= (cfg_ff.both_edge & ~wmask[7:0]) | (wdata_ff[7:0] & wmask[7:0]);
            A_INVERT: cfg_ff.invert <= (cfg_ff.invert & ~wmask[7:0]) | (wdata_ff[7:0] & wmask[7:0]);
            A_ENC_EN: if (wstrb_ff[0]) cfg_ff.enc_en <= wdata_ff[2:0];
            A_OUT_LVL: if (wstrb_ff[0]) out_lvl_ff <= wdata_ff[7:0] & OUT_CAPABLE;
            A_PULSE_LEN: pulse_len_ff <= (pulse_len_ff & ~wmask[15:0]) | (wdata_ff[15:0] & wmask[15:0]);
            A_LVL_SEL: if (wstrb_ff[0]) lvl_sel_ff <= wdata_ff[1:0];
            A_ALARM: if (wstrb_ff[0] && wdata_ff[7:0] >= THR_MIN) alarm_ff <= wdata_ff[7:0];
            default: ;
         endcase
      end
   end
   assign alarm_clr = (wr_go && awaddr_ff == A_STAT && wstrb_ff[0]) ? wdata_ff[7:0] : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Sample tick and timebase
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in || mode_ff == DIOC_STOP)
         tick_cnt_ff <= 32'h0000_0000;
      else if (tick)
         tick_cnt_ff <= 32'h0000_0000;
      else
         tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
   end
   assign tick = (mode_ff == DIOC_RUN) && (tick_cnt_ff == SAMPLE_CYCLES - 1);

   // Timestamp clock in sample ticks
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in || run_pulse)
         time_ff <= 32'h0000_0000;
      else if (tick)
         time_ff <= time_ff + 32'h0000_0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fast line prescaler, toggles every eight of its own rising samples (divide by sixteen)
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         pre_ff <= 3'h0;
         pre_q_ff <= 1'b0;
         fast_prev_ff <= 1'b0;
      end
      else if (run_pulse)
         fast_prev_ff <= line_in[0];
      else if (tick)
      begin
         fast_prev_ff <= line_in[0];
         if (line_in[0] && !fast_prev_ff)
         begin
            pre_ff <= pre_ff + 3'h1;
            if (pre_ff == 3'(PRESCALE - 1))
               pre_q_ff <= ~pre_q_ff;
         end
      end
   end
   assign samp = {line_in[7:1], pre_q_ff};

   // Lines owned by an enabled encoder pair; pair one-two never encodes
   assign enc_lines = {{2{cfg_ff.enc_en[2]}}, {2{cfg_ff.enc_en[1]}}, {2{cfg_ff.enc_en[0]}}, 2'b00};

   ////////////////////////////////////////////////////////////////////////////
   // Per-line filter and counter
   genvar g;
   generate
      for (g = 0; g < NLINES; g++)
      begin : g_line
         logic enc_line;
         logic src;
         assign enc_line = enc_lines[g];
         assign src = ((cfg_ff.filt_en[g] && !enc_line) ? filt_out_ff[g] : samp[g]) ^ cfg_ff.invert[g];
         assign cnt_step[g] = tick && !enc_line &&
            (cfg_ff.both_edge[g] ? (src != cnt_in_prev_ff[g]) : (src && !cnt_in_prev_ff[g]));

         // Threshold register
         always_ff @(posedge core_clk_in)
         begin
            if (rst_in)
               thr_ff[g] <= THR_RST;
            else if (wr_go && awaddr_ff == A_THR0 + 8'(4 * g) && wstrb_ff[0] && wdata_ff[7:0] >= THR_MIN)
               thr_ff[g] <= wdata_ff[7:0];
         end

         // Up-down filter
         always_ff @(posedge core_clk_in)
         begin
            if (rst_in)
            begin
               filt_cnt_ff[g] <= 8'h00;
               filt_out_ff[g] <= 1'b0;
            end
            else if (run_pulse)
            begin
               filt_out_ff[g] <= samp[g];
               filt_cnt_ff[g] <= samp[g] ? thr_ff[g] : 8'h00;
            end
            else if (tick)
            begin
               if (samp[g] && filt_cnt_ff[g] < thr_ff[g])
                  filt_cnt_ff[g] <= filt_cnt_ff[g] + 8'h01;
               else if (!samp[g] && filt_cnt_ff[g] != 8'h00)
                  filt_cnt_ff[g] <= filt_cnt_ff[g] - 8'h01;
               if (samp[g] && {1'b0, filt_cnt_ff[g]} + 9'h001 >= {1'b0, thr_ff[g]})
                  filt_out_ff[g] <= 1'b1;
               else if (!samp[g] && filt_cnt_ff[g] <= 8'h01)
                  filt_out_ff[g] <= 1'b0;
            end
         end

         // Edge counter, timestamp and alarm
         always_ff @(posedge core_clk_in)
         begin
            if (rst_in)
            begin
               cnt_ff[g] <= 32'h0000_0000;
               ts_ff[g] <= 32'h0000_0000;
               since_ff[g] <= 8'h00;
               alarm_flag_ff[g] <= 1'b0;
               cnt_in_prev_ff[g] <= 1'b0;
            end
            else
            begin
               if (run_pulse)
                  cnt_in_prev_ff[g] <= samp[g] ^ cfg_ff.invert[g];
               else if (tick)
                  cnt_in_prev_ff[g] <= src;
               if (cnt_step[g])
               begin
                  cnt_ff[g] <= cnt_ff[g] + 32'h0000_0001;
                  ts_ff[g] <= time_ff;
               end
               if (cnt_step[g] && since_ff[g] + 8'h01 >= alarm_ff)
                  since_ff[g] <= 8'h00;
               else if (cnt_step[g])
                  since_ff[g] <= since_ff[g] + 8'h01;
               // Set wins over software clear
               if (cnt_step[g] && since_ff[g] + 8'h01 >= alarm_ff)
                  alarm_flag_ff[g] <= 1'b1;
               else if (alarm_clr[g])
                  alarm_flag_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Quadrature encoders on pairs 3-4, 5-6, 7-8
   generate
      for (g = 0; g < 3; g++)
      begin : g_enc
         logic [1:0] ab;
         assign ab = {samp[2 * g + 3], samp[2 * g + 2]};
         always_ff @(posedge core_clk_in)
         begin
            if (rst_in)
            begin
               enc_ff[g] <= 32'h0000_0000;
               enc_ts_ff[g] <= 32'h0000_0000;
               enc_prev_ff[g] <= 2'b00;
            end
            else if (run_pulse)
               enc_prev_ff[g] <= ab;
            else if (tick)
            begin
               // Phase history kept while disabled so enabling adds no false step
               enc_prev_ff[g] <= ab;
               if (!cfg_ff.enc_en[g])
                  enc_ff[g] <= enc_ff[g];
               else if ({enc_prev_ff[g], ab} == 4'b0001 || {enc_prev_ff[g], ab} == 4'b0111 ||
                   {enc_prev_ff[g], ab} == 4'b1110 || {enc_prev_ff[g], ab} == 4'b1000)
               begin
                  enc_ff[g] <= enc_ff[g] + 32'h0000_0001;
                  enc_ts_ff[g] <= time_ff;
               end
               else if ({enc_prev_ff[g], ab} == 4'b0010 || {enc_prev_ff[g], ab} == 4'b1011 ||
                        {enc_prev_ff[g], ab} == 4'b1101 || {enc_prev_ff[g], ab} == 4'b0100)
               begin
                  enc_ff[g] <= enc_ff[g] - 32'h0000_0001;
                  enc_ts_ff[g] <= time_ff;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Output pulse timer, counts sample ticks, ignored when stopped
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         pulse_act_ff <= 8'h00;
         pulse_cnt_ff <= 16'h0000;
      end
      else if (wr_go && awaddr_ff == A_PULSE_GO && wstrb_ff[0] && mode_ff == DIOC_RUN)
      begin
         pulse_act_ff <= wdata_ff[7:0] & OUT_CAPABLE;
         pulse_cnt_ff <= pulse_len_ff;
      end
      else if (tick && pulse_act_ff != 8'h00)
      begin
         if (pulse_cnt_ff <= 16'h0001)
            pulse_act_ff <= 8'h00;
         pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
      end
   end

   // Open-drain pins: on sinks the pin low, off releases it
   always_ff @(posedge core_clk_in)
   begin
      if (rst_in)
      begin
         line_oe_out <= 8'h00;
         line_o_out <= 8'h00;
         level_sel_out <= 2'b00;
         run_out <= 1'b0;
      end
      else
      begin
         line_oe_out <= (out_lvl_ff | pulse_act_ff) & OUT_CAPABLE;
         line_o_out <= 8'h00;
         level_sel_out <= lvl_sel_ff;
         run_out <= mode_ff == DIOC_RUN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_no_tick_stop: assert property (@(posedge core_clk_in) disable iff (rst_in)
      mode_ff == DIOC_STOP && !run_pulse |=> $stable(time_ff) && $stable(filt_out_ff))
      else $error("sampling while stopped");
   a_filt_sat: assert property (@(posedge core_clk_in) disable iff (rst_in)
      filt_cnt_ff[0] <= thr_ff[0] || $changed(thr_ff[0]) || run_pulse || $past(run_pulse))
      else $error("filter above threshold");
   a_input_only: assert property (@(posedge core_clk_in) disable iff (rst_in)
      !line_oe_out[0] && !line_oe_out[7]) else $error("input-only line driven");
   a_cnt_inc: assert property (@(posedge core_clk_in) disable iff (rst_in)
      cnt_step[1] |=> cnt_ff[1] == $past(cnt_ff[1]) + 32'h0000_0001) else $error("counter step");
   a_ts_cap: assert property (@(posedge core_clk_in) disable iff (rst_in)
      cnt_step[2] |=> ts_ff[2] == $past(time_ff)) else $error("timestamp");
   a_pulse_oe: assert property (@(posedge core_clk_in) disable iff (rst_in)
      pulse_act_ff[3] |=> line_oe_out[3]) else $error("pulse not driven");
   a_run_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
      run_pulse |=> filt_out_ff[4] == $past(samp[4])) else $error("filter preload");
   a_sink_only: assert property (@(posedge core_clk_in) disable iff (rst_in)
      out_lvl_ff[5] |=> line_oe_out[5] && line_o_out == 8'h00) else $error("output one not sunk");
endmodule // dioc_top
`default_nettype wire

// *** tb/dioc_sensor.sv ***
// Far-side model: sensor drivers, pin pull-ups and the open-drain wired level.
// Assumes pin levels are settled before the core samples them.
`timescale 1ns/1ps
`default_nettype none
module dioc_sensor
(
   input wire logic [7:0] drive_lvl_in,
   input wire logic [7:0] sink_in,
   output logic [7:0] pin_out
);
   // A sunk pin reads low, otherwise the sensor or pull-up level
   assign pin_out = drive_lvl_in & ~sink_in;
endmodule // dioc_sensor
`default_nettype wire

// *** tb/dioc_top_test.sv ***
// Self-checking bench for the digital I/O counter block.
// Assumes a short sample tick (4 cycles) and a register master on AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dioc_top_test;
   import dioc_pkg::*;
   logic clk, rst, run, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] lvl, pins, oe, od, awaddr, araddr;
   logic [1:0] lsel, bresp, rresp;
   logic [31:0] wdata, rdata, d, t, e;
   logic [3:0] wstrb;
   int errors, compares, n;
   int cyc = 0;
   //////////////////////////////////////////////////////////////////
   dioc_top #(.SAMPLE_CYCLES(4)) dioc_top_i (.core_clk_in(clk), .rst_in(rst), .line_in(pins),
      .line_oe_out(oe), .line_o_out(od), .level_sel_out(lsel), .run_out(run),
      .s_awaddr_in(awaddr), .s_awvalid_in(awvalid), .s_awready_out(awready), .s_wdata_in(wdata),
      .s_wstrb_in(wstrb), .s_wvalid_in(wvalid), .s_wready_out(wready), .s_bresp_out(bresp),
      .s_bvalid_out(bvalid), .s_bready_in(bready), .s_araddr_in(araddr), .s_arvalid_in(arvalid),
      .s_arready_out(arready), .s_rdata_out(rdata), .s_rresp_out(rresp), .s_rvalid_out(rvalid),
      .s_rready_in(rready));
   dioc_sensor dioc_sensor_i (.drive_lvl_in(lvl), .sink_in(oe), .pin_out(pins));
   // Clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
      cyc <= cyc + 1;
   //////////////////////////////////////////////////////////////////
   task automatic results();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Register write, both beats offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
      logic aw, w;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      do
      begin
         @(posedge clk);
         if (awready && !aw)
         begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !w)
         begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(aw && w && bvalid));
      bready <= 1'b0;
      chk(32'(bresp), 32'(er));
   endtask
   // Register read with response and data check
   task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er = RESP_OKAY);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready && arvalid)
            arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      rready <= 1'b0;
      chk(32'(rresp), 32'(er));
      if (x !== 32'hFFFF_FFFF)
         chk(d, x);
   endtask
   // Low-then-high pulses on the masked lines
   task automatic pls(input logic [7:0] m, input int k, input int h);
      repeat (k)
      begin
         lvl <= lvl & ~m;
         repeat (h) @(posedge clk);
         lvl <= lvl | m;
         repeat (h) @(posedge clk);
      end
   endtask
   // One quadrature cycle on lines three and four
   task automatic enc(input bit rev);
      logic [1:0] q[4];
      q = '{2'b10, 2'b00, 2'b01, 2'b11};
      for (int i = 0; i < 4; i++)
      begin
         lvl[3:2] <= rev ? q[(6 - i) % 4] : q[i];
         repeat (8) @(posedge clk);
      end
   endtask
   //////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(32'(oe), 32'h0000_0000);
      rc(A_CTRL, 32'h0000_0000);
      rc(A_PULSE_LEN, 32'h0000_0001);
      wr(A_THR0 + 8'h08, 32'h0000_0000);
      rc(A_THR0 + 8'h08, 32'h0000_0001);
      wr(A_THR0 + 8'h0C, 32'h0000_00FF);
      rc(A_THR0 + 8'h0C, 32'h0000_00FF);
      rc(8'h3C, 32'h0000_0000, RESP_SLVERR);
      wr(8'h30, 32'h0000_0001, RESP_SLVERR);
   endtask
   task automatic t_idle();
      pls(8'h1B, 2, 8);
      rc(A_CNT0 + 8'h04, 32'h0000_0000);
      rc(A_TIME, 32'h0000_0000);
   endtask
   task automatic t_count();
      wr(A_ALARM, 32'h0000_0004);
      wr(A_BOTH_EDGE, 32'h0000_0009);
      wr(A_INVERT, 32'h0000_0010);
      wr(A_FILT_EN, 32'h0000_0004);
      wr(A_THR0 + 8'h08, 32'h0000_0003);
      wr(A_CTRL, 32'h0000_0001);
      @(posedge clk);
      chk(32'(run), 32'h0000_0001);
      pls(8'h1B, 8, 8);
      rc(A_CNT0, 32'h0000_0001);
      rc(A_CNT0 + 8'h04, 32'h0000_0008);
      rc(A_CNT0 + 8'h0C, 32'h0000_0010);
      rc(A_CNT0 + 8'h10, 32'h0000_0008);
      rc(A_STAT, 32'hFFFF_FFFF);
      chk(32'(d[7:0]), 32'h0000_001A);
      wr(A_STAT, 32'h0000_00FF);
      rc(A_STAT, 32'hFFFF_FFFF);
      chk(32'(d[7:0]), 32'h0000_0000);
      rc(A_TS0 + 8'h04, 32'hFFFF_FFFF);
      t = d;
      rc(A_TIME, 32'hFFFF_FFFF);
      chk(32'(t != 0 && t <= d), 32'h0000_0001);
   endtask
   task automatic t_filter();
      pls(8'h04, 1, 4);
      pls(8'h04, 1, 24);
      rc(A_CNT0 + 8'h08, 32'h0000_0001);
      rc(A_STAT, 32'hFFFF_FFFF);
      chk(32'(d[10]), 32'h0000_0001);
   endtask
   task automatic t_enc();
      wr(A_ENC_EN, 32'h0000_0001);
      enc(1'b0);
      rc(A_ENC0, 32'hFFFF_FFFF);
      e = d;
      chk(32'(e == 32'h0000_0004 || e == 32'hFFFF_FFFC), 32'h0000_0001);
      enc(1'b1);
      rc(A_ENC0, 32'h0000_0000);
      enc(1'b1);
      rc(A_ENC0, 32'h0000_0000 - e);
      rc(A_CNT0 + 8'h08, 32'h0000_0001);
      wr(A_ENC_EN, 32'h0000_0000);
   endtask
   task automatic t_out();
      wr(A_OUT_LVL, 32'h0000_00FF);
      repeat (3) @(posedge clk);
      chk(32'(oe), 32'h0000_007E);
      chk(32'(pins), 32'h0000_0081);
      chk(32'(od), 32'h0000_0000);
      wr(A_OUT_LVL, 32'h0000_0000);
      wr(A_LVL_SEL, 32'h0000_0002);
      repeat (3) @(posedge clk);
      chk(32'(oe), 32'h0000_0000);
      chk(32'(lsel), 32'h0000_0002);
      wr(A_PULSE_LEN, 32'h0000_0003);
      wr(A_PULSE_GO, 32'h0000_0048);
      n = 0;
      repeat (60)
      begin
         @(posedge clk);
         n += int'(oe[6]);
      end
      chk(32'(n >= 8 && n <= 16), 32'h0000_0001);
      chk(32'(oe), 32'h0000_0000);
      wr(A_CTRL, 32'h0000_0000);
      wr(A_PULSE_GO, 32'h0000_0048);
      repeat (3) @(posedge clk);
      chk(32'(oe), 32'h0000_0000);
      chk(32'(run), 32'h0000_0000);
   endtask
   //////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      lvl = 8'hFF;
      rst = 1'b1;
      errors = 0;
      compares = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      fork
         begin
            t_reset();
            t_idle();
            t_count();
            t_filter();
            t_enc();
            t_out();
         end
         begin
            wait (cyc >= 20000);
            errors++;
         end
      join_any
      results();
   end
endmodule // dioc_top_test
`default_nettype wire
